// [rtl/sbmc_top.sv]
// System bus master control: arbitration, strobes, interrupts, resets, mapper
`timescale 1ns/1ps
`default_nettype none
module sbmc_top
    import sbmc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [6:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Processor core side
    input  wire logic        cpu_mem_valid,
    input  wire sbmc_mreq_t  cpu_mem_req,
    output logic             cpu_mem_done,
    input  wire logic        cpu_reset_instr,
    input  wire logic        cpu_load_req,
    output logic             cpu_reset,
    output logic             cpu_int_req,
    output logic      [3:0]  cpu_int_level,
    output logic             cpu_nmi_trap,
    output logic             ctx_valid,
    output sbmc_ctx_t        ctx_vector,
    // System bus pins
    input  wire logic        bus_request_n,
    output logic             bus_grant,
    output logic             bus_oe_n,
    output logic             instruction_fetch_flag,
    input  wire logic [14:0] interrupt_level_n,
    output logic             io_reset_out_n,
    input  wire logic        power_on_reset_n,
    input  wire logic        trap_request_n,
    output logic             mem_cycle_active_n,
    output logic             mem_access_active_n,
    output logic             read_direction,
    input  wire logic        ready,
    output logic      [15:0] mem_address,
    output logic      [3:0]  extended_address_lines,
    output logic             system_bus_clock_n,
    output logic             reference_timing_clock_n
);

    // Lowest level number among active lines wins
    function automatic logic [3:0] pri_enc(input logic [14:0] v);
        logic [3:0] lvl;
        lvl = 4'h0;
        for (int i = 14; i >= 0; i--) begin
            if (v[i]) begin
                lvl = 4'(i + 1);
            end
        end
        return lvl;
    endfunction

    // Input synchronisers: {bus_req, ready, por, trap, int}
    logic [18:0] sync1_ff;
    logic [18:0] sync2_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {bus_request_n, ready, power_on_reset_n,
                         trap_request_n, interrupt_level_n};
            sync2_ff <= sync1_ff;
        end
    end
    logic        req_s;
    logic        rdy_s;
    logic        por_s;
    logic        trap_s;
    logic [14:0] int_s;
    assign req_s  = ~sync2_ff[18];
    assign rdy_s  = sync2_ff[17];
    assign por_s  = ~sync2_ff[16];
    assign trap_s = ~sync2_ff[15];
    assign int_s  = ~sync2_ff[14:0];
    assign cpu_reset = por_s;

    // Bus clock divider; strobes change with its rising edge
    logic [2:0] bdiv_ff;
    logic       system_bus_clock_n_ff;
    logic       bus_wrap;
    logic       bus_rise;
    assign bus_wrap = (bdiv_ff == BUS_HALF_CYC - 3'h1);
    assign bus_rise = bus_wrap && !system_bus_clock_n_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            bdiv_ff   <= 3'h0;
            system_bus_clock_n_ff <= 1'b0;
        end else if (bus_wrap) begin
            bdiv_ff   <= 3'h0;
            system_bus_clock_n_ff <= ~system_bus_clock_n_ff;
        end else begin
            bdiv_ff <= bdiv_ff + 3'h1;
        end
    end
    assign system_bus_clock_n = system_bus_clock_n_ff;

    // Fractional divider: exact 3 MHz average, one-cycle jitter
    logic [7:0] ref_acc_ff;
    logic [7:0] nxt_ref_acc;
    logic       reference_timing_clock_n_ff;
    logic       ref_tog;
    logic       ref_rise;
    assign nxt_ref_acc = ref_acc_ff + REF_STEP;
    assign ref_tog     = (nxt_ref_acc >= REF_MOD);
    assign ref_rise    = ref_tog && !reference_timing_clock_n_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_acc_ff <= 8'h00;
            reference_timing_clock_n_ff  <= 1'b0;
        end else if (ref_tog) begin
            ref_acc_ff <= nxt_ref_acc - REF_MOD;
            reference_timing_clock_n_ff  <= ~reference_timing_clock_n_ff;
        end else begin
            ref_acc_ff <= nxt_ref_acc;
        end
    end
    assign reference_timing_clock_n = reference_timing_clock_n_ff;

    // Register file
    logic        map_on_ff;
    logic        acc_on_ff;
    logic [3:0]  mask_ff;
    logic [7:0]  page_ff [16];
    logic        ack_ff;
    logic        acc_ok;
    logic        wr_go;
    logic        sw_rst_instr;
    logic        sw_load;
    logic        is_map;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign wr_go  = avs_write && ack_ff;
    assign is_map = (avs_address[6] == REG_MAP_BASE[6]);
    assign acc_ok = (map_on_ff == acc_on_ff);
    assign sw_rst_instr = wr_go && avs_address == REG_CTRL
                          && avs_byteenable[0] && avs_writedata[CTRL_RST_INSTR];
    assign sw_load = wr_go && avs_address == REG_CTRL
                     && avs_byteenable[0] && avs_writedata[CTRL_LOAD];

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || por_s) begin
            map_on_ff <= MAP_ON_RESET;
            acc_on_ff <= ACC_ON_RESET;
            mask_ff   <= MASK_RESET;
        end else if (wr_go && avs_address == REG_CTRL && avs_byteenable[0]) begin
            map_on_ff <= avs_writedata[CTRL_MAP_ON];
            acc_on_ff <= avs_writedata[CTRL_ACC_ON];
        end else if (wr_go && avs_address == REG_MASK && avs_byteenable[1]) begin
            mask_ff <= avs_writedata[MASK_LSB +: 4];
        end
    end

    // Page registers; a page is 4 K bytes of the extended space
    always_ff @(posedge clk) begin
        if (rst || por_s) begin
            for (int i = 0; i < 16; i++) begin
                page_ff[i] <= PAGE_RESET;
            end
        end else if (wr_go && is_map && acc_ok && avs_byteenable[0]) begin
            page_ff[avs_address[5:2]] <= avs_writedata[7:0];
        end
    end

    // Interrupt priority and mask
    logic [14:0] int_en;
    logic [3:0]  int_lvl;
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            int_en[i] = int_s[i] && (4'(i + 1) <= mask_ff);
        end
    end
    assign int_lvl = pri_enc(int_en);
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_int_req   <= 1'b0;
            cpu_int_level <= 4'h0;
        end else begin
            cpu_int_req   <= (int_lvl != 4'h0);
            cpu_int_level <= int_lvl;
        end
    end

    // Register read path
    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[STAT_GRANT]             = bus_grant;
        status_w[STAT_INT]               = cpu_int_req;
        status_w[STAT_LVL_LSB +: 4]      = cpu_int_level;
        status_w[STAT_IO_RESET_OUT_N]             = !io_reset_out_n;
        status_w[STAT_LINE_LSB +: 15]    = int_s;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            avs_readdata <= 32'h0000_0000;
            if (is_map) begin
                if (acc_ok) begin
                    avs_readdata[7:0] <= page_ff[avs_address[5:2]];
                end
            end else begin
                case (avs_address)
                    REG_CTRL: begin
                        avs_readdata[CTRL_MAP_ON] <= map_on_ff;
                        avs_readdata[CTRL_ACC_ON] <= acc_on_ff;
                    end
                    REG_MASK:   avs_readdata[MASK_LSB +: 4] <= mask_ff;
                    REG_STATUS: avs_readdata <= status_w;
                    default:    avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // I/O reset stretch, counted in reference clock rising edges
    logic [1:0] io_reset_out_n_cnt_ff;
    logic       io_reset_out_n_src;
    assign io_reset_out_n_src = por_s || cpu_reset_instr || sw_rst_instr;
    always_ff @(posedge clk) begin
        if (rst) begin
            io_reset_out_n_cnt_ff   <= 2'h0;
            io_reset_out_n <= 1'b1;
        end else begin
            // One extra edge covers the partial first reference period
            if (io_reset_out_n_src) begin
                io_reset_out_n_cnt_ff <= IO_RESET_OUT_N_MIN_REF + 2'h1;
            end else if (ref_rise && io_reset_out_n_cnt_ff != 2'h0) begin
                io_reset_out_n_cnt_ff <= io_reset_out_n_cnt_ff - 2'h1;
            end
            io_reset_out_n <= !(io_reset_out_n_src || io_reset_out_n_cnt_ff != 2'h0);
        end
    end

    // Trap filter; a pulse shorter than the minimum is dropped
    logic [3:0] trap_cnt_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            trap_cnt_ff  <= 4'h0;
            cpu_nmi_trap <= 1'b0;
        end else begin
            cpu_nmi_trap <= 1'b0;
            if (!trap_s) begin
                trap_cnt_ff <= 4'h0;
            end else if (trap_cnt_ff != 4'(TRAP_MIN_CYC)) begin
                trap_cnt_ff  <= trap_cnt_ff + 4'h1;
                cpu_nmi_trap <= (trap_cnt_ff == 4'(TRAP_MIN_CYC - 1));
            end
        end
    end

    // Context switch vectors on power-on release or load
    logic por_d_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            por_d_ff   <= 1'b0;
            ctx_valid  <= 1'b0;
            ctx_vector <= '0;
        end else begin
            por_d_ff  <= por_s;
            ctx_valid <= 1'b0;
            if (por_d_ff && !por_s) begin
                ctx_valid  <= 1'b1;
                ctx_vector <= '{wp: VEC_RESET_WP, pc: VEC_RESET_PC};
            end else if (cpu_load_req || sw_load) begin
                ctx_valid  <= 1'b1;
                ctx_vector <= '{wp: VEC_LOAD_WP, pc: VEC_LOAD_PC};
            end
        end
    end

    // Bus cycle and arbitration
    sbmc_state_t state_ff;
    sbmc_mreq_t  cyc_req_ff;
    logic [19:0] phys;
    logic [7:0]  cur_page;
    assign cur_page = page_ff[cpu_mem_req.addr[15:12]];
    assign phys = map_on_ff ? {cur_page, cpu_mem_req.addr[11:0]}
                            : {4'h0, cpu_mem_req.addr};

    always_ff @(posedge clk) begin
        if (rst || por_s) begin
            state_ff               <= ST_IDLE;
            cyc_req_ff             <= '0;
            bus_grant              <= 1'b0;
            bus_oe_n               <= 1'b0;
            mem_cycle_active_n     <= 1'b1;
            mem_access_active_n    <= 1'b1;
            read_direction         <= 1'b0;
            instruction_fetch_flag <= 1'b0;
            mem_address            <= 16'h0000;
            extended_address_lines <= 4'h0;
            cpu_mem_done           <= 1'b0;
        end else begin
            cpu_mem_done <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (bus_rise && req_s) begin
                        state_ff  <= ST_GRANT;
                        bus_grant <= 1'b1;
                        bus_oe_n  <= 1'b1;
                    end else if (bus_rise && cpu_mem_valid) begin
                        state_ff               <= ST_CYC;
                        cyc_req_ff             <= cpu_mem_req;
                        mem_cycle_active_n     <= 1'b0;
                        mem_access_active_n    <= 1'b0;
                        read_direction         <= cpu_mem_req.read;
                        instruction_fetch_flag <= cpu_mem_req.fetch;
                        mem_address            <= phys[15:0];
                        extended_address_lines <= phys[19:16];
                    end
                end
                ST_CYC: begin
                    // Ready is sampled synchronised, so a wait costs one bus clock
                    if (bus_rise && !(cyc_req_ff.ack_wait && !rdy_s)) begin
                        state_ff               <= ST_IDLE;
                        mem_cycle_active_n     <= 1'b1;
                        mem_access_active_n    <= 1'b1;
                        instruction_fetch_flag <= 1'b0;
                        cpu_mem_done           <= 1'b1;
                    end
                end
                ST_GRANT: begin
                    if (bus_rise && !req_s) begin
                        state_ff  <= ST_IDLE;
                        bus_grant <= 1'b0;
                        bus_oe_n  <= 1'b0;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Reference edges seen while I/O reset is low
    logic [2:0] ref_seen_ff;
    always_ff @(posedge clk) begin
        if (rst || io_reset_out_n) begin
            ref_seen_ff <= 3'h0;
        end else if (ref_rise && ref_seen_ff != 3'h7) begin
            ref_seen_ff <= ref_seen_ff + 3'h1;
        end
    end

    sequence s_single_start;
        $fell(mem_cycle_active_n) && !cyc_req_ff.ack_wait;
    endsequence
    sequence s_wait_seen;
        state_ff == ST_CYC && bus_rise && cyc_req_ff.ack_wait && !rdy_s;
    endsequence

    a_grant_from_idle: assert property ($rose(bus_grant) |-> $past(state_ff) == ST_IDLE
                                        && mem_cycle_active_n)
        else $error("grant raised while a cycle ran");
    a_fetch_in_cycle: assert property (instruction_fetch_flag |-> !mem_cycle_active_n)
        else $error("fetch flag outside a memory cycle");
    a_int_priority: assert property (cpu_int_req |-> cpu_int_level != 4'h0
                                     && ($past(int_en) & ((15'h1 << (cpu_int_level - 4'h1)) - 15'h1)) == 15'h0)
        else $error("interrupt level is not the highest enabled one");
    // Level is registered, so it is held against last cycle's mask
    a_int_mask_gate: assert property (cpu_int_req |-> cpu_int_level <= $past(mask_ff))
        else $error("masked interrupt level presented");
    a_io_reset_out_n_hold: assert property ($rose(io_reset_out_n) |-> $past(ref_seen_ff) >= 3'h2)
        else $error("I/O reset shorter than two reference cycles");
    a_por_io_reset_out_n: assert property (por_s |=> !io_reset_out_n)
        else $error("I/O reset not driven on power-on reset");
    a_reset_vector: assert property ($fell(por_s) |=> ctx_valid
                                     && ctx_vector.wp == VEC_RESET_WP && ctx_vector.pc == VEC_RESET_PC)
        else $error("reset vectors wrong");
    a_load_vector: assert property ((cpu_load_req && !($past(por_s) && !por_s)) |=>
                                    ctx_valid && ctx_vector.pc == VEC_LOAD_PC)
        else $error("load vectors wrong");
    a_map_off_pass: assert property ($fell(mem_cycle_active_n) && !map_on_ff
                                     |-> extended_address_lines == 4'h0)
        else $error("address extended with mapper off");
    a_single_end: assert property (s_single_start |-> ##8 $rose(mem_cycle_active_n))
        else $error("single access did not end at next bus clock edge");
    a_ready_wait: assert property (s_wait_seen |=> !mem_cycle_active_n [*8])
        else $error("cycle ended while ready was low");
    a_dir_read: assert property (!mem_cycle_active_n |-> read_direction == cyc_req_ff.read)
        else $error("direction does not match access");
    a_trap_width: assert property (cpu_nmi_trap |-> $past(trap_s, 10)
                                   && io_reset_out_n == $past(io_reset_out_n))
        else $error("trap taken on short pulse");

endmodule // sbmc_top
`default_nettype wire

// [inc/sbmc_pkg.sv]
// Constants and carrier types for the system bus master control block
`default_nettype none
package sbmc_pkg;
    // Timing
    localparam int CLK_MHZ       = 100;
    localparam int TRAP_MIN_NS   = 100;
    localparam int TRAP_MIN_CYC  = (TRAP_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_KHZ       = 3000;
    localparam logic [7:0] REF_STEP = 8'(2 * REF_KHZ / 1000);
    localparam logic [7:0] REF_MOD  = 8'(CLK_MHZ);
    localparam logic [2:0] BUS_HALF_CYC = 3'h4;
    localparam logic [1:0] IO_RESET_OUT_N_MIN_REF = 2'h2;
    // Context switch vectors
    localparam logic [15:0] VEC_RESET_WP = 16'h0000;
    localparam logic [15:0] VEC_RESET_PC = 16'h0002;
    localparam logic [15:0] VEC_LOAD_WP  = 16'hfffc;
    localparam logic [15:0] VEC_LOAD_PC  = 16'hfffe;
    // Register byte offsets
    localparam logic [6:0] REG_CTRL     = 7'h00;
    localparam logic [6:0] REG_MASK     = 7'h04;
    localparam logic [6:0] REG_STATUS   = 7'h08;
    localparam logic [6:0] REG_MAP_BASE = 7'h40;
    // Field positions
    localparam int CTRL_MAP_ON    = 0;
    localparam int CTRL_ACC_ON    = 1;
    localparam int CTRL_RST_INSTR = 2;
    localparam int CTRL_LOAD      = 3;
    localparam int MASK_LSB       = 12;
    localparam int STAT_GRANT     = 0;
    localparam int STAT_INT       = 1;
    localparam int STAT_LVL_LSB   = 4;
    localparam int STAT_IO_RESET_OUT_N     = 8;
    localparam int STAT_LINE_LSB  = 16;
    // Reset values
    localparam logic       MAP_ON_RESET = 1'b0;
    localparam logic       ACC_ON_RESET = 1'b0;
    localparam logic [3:0] MASK_RESET   = 4'h0;
    localparam logic [7:0] PAGE_RESET   = 8'h00;
    // Bus cycle states, Gray along idle-cycle-idle and idle-grant-idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CYC   = 2'b01,
        ST_GRANT = 2'b10
    } sbmc_state_t;
    // Memory request from the processor core
    typedef struct packed {
        logic        read;
        logic        fetch;
        logic        ack_wait;
        logic [15:0] addr;
    } sbmc_mreq_t;
    // Context switch vector pair
    typedef struct packed {
        logic [15:0] wp;
        logic [15:0] pc;
    } sbmc_ctx_t;
endpackage
`default_nettype wire

// [verification/sbmc_partner.sv]
// Far-side model: slow memory module and a second bus master
`timescale 1ns/1ps
`default_nettype none
module sbmc_partner (
    // Clock
    input  wire logic       clk,
    // System bus
    input  wire logic       mem_cycle_active_n,
    input  wire logic       system_bus_clock_n,
    output logic            ready,
    output logic            bus_request_n,
    // Bench control
    input  wire logic [3:0] wait_clocks,
    input  wire logic       want_bus
);
    logic [3:0] left_ff;
    logic       bclk_ff;
    // Wait length counted in bus clock rising edges
    always_ff @(posedge clk) begin
        bclk_ff <= system_bus_clock_n;
        if (mem_cycle_active_n) begin
            left_ff <= wait_clocks;
        end else if (!bclk_ff && system_bus_clock_n && left_ff != 4'h0) begin
            left_ff <= left_ff - 4'h1;
        end
    end
    // Open collector with pull-up: released reads high
    assign ready         = !(!mem_cycle_active_n && left_ff != 4'h0);
    assign bus_request_n = !want_bus;
endmodule // sbmc_partner
`default_nettype wire

// [verification/system_bus_master_control_bench.sv]
// Self-checking bench for the system bus master control block
`timescale 1ns/1ps
`default_nettype none
module system_bus_master_control_bench import sbmc_pkg::*;;
    logic        clk, rst, avs_read, avs_write, cpu_mem_valid, cpu_reset_instr, cpu_load_req, want_bus;
    logic        power_on_reset_n, trap_request_n, avs_waitrequest, cpu_mem_done, cpu_reset, cpu_int_req;
    logic        cpu_nmi_trap, ctx_valid, bus_request_n, bus_grant, bus_oe_n, instruction_fetch_flag, ready;
    logic        io_reset_out_n, mem_cycle_active_n, mem_access_active_n, read_direction, rq;
    logic        system_bus_clock_n, reference_timing_clock_n, bq;
    logic [3:0]  avs_byteenable, cpu_int_level, extended_address_lines, wait_clocks;
    logic [6:0]  avs_address;
    logic [14:0] interrupt_level_n;
    logic [15:0] mem_address;
    logic [19:0] ph;
    logic [31:0] avs_writedata, avs_readdata, q;
    sbmc_mreq_t  cpu_mem_req;
    sbmc_ctx_t   ctx_vector, last_ctx;
    int          bad_count, total_checks, n, refs, r0, traps, bus_edges;

    sbmc_top i_sbmc_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cpu_mem_valid, .cpu_mem_req, .cpu_mem_done, .cpu_reset_instr,
        .cpu_load_req, .cpu_reset, .cpu_int_req, .cpu_int_level, .cpu_nmi_trap, .ctx_valid, .ctx_vector,
        .bus_request_n, .bus_grant, .bus_oe_n, .instruction_fetch_flag, .interrupt_level_n, .io_reset_out_n,
        .power_on_reset_n, .trap_request_n, .mem_cycle_active_n, .mem_access_active_n, .read_direction,
        .ready, .mem_address, .extended_address_lines, .system_bus_clock_n, .reference_timing_clock_n);
    sbmc_partner i_sbmc_partner (.clk, .mem_cycle_active_n, .system_bus_clock_n, .ready, .bus_request_n,
        .wait_clocks, .want_bus);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulse outputs last one cycle, so they are caught here
    always @(posedge clk) begin
        rq <= reference_timing_clock_n;
        if (!rq && reference_timing_clock_n) refs++;
        bq <= system_bus_clock_n;
        if (!bq && system_bus_clock_n) bus_edges++;
        if (ctx_valid === 1'b1) last_ctx <= ctx_vector;
        if (cpu_nmi_trap === 1'b1) traps++;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task endt(input string s);
        $display("test %0s done, %0d mismatches", s, bad_count);
    endtask
    task automatic wt(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (s !== v) begin
            bad_count++;
            $display("[FAIL] %0t wait limit reached", $time);
        end
    endtask
    task av(input logic wr, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task mem(input sbmc_mreq_t r);
        @(posedge clk);
        cpu_mem_valid <= 1'b1;
        cpu_mem_req <= r;
        wt(mem_cycle_active_n, 1'b0);
        ph = {extended_address_lines, mem_address};
        chk(mem_access_active_n, 0);
        chk(read_direction, r.read);
        chk(instruction_fetch_flag, r.fetch);
        wt(cpu_mem_done, 1'b1);
        cpu_mem_valid <= 1'b0;
        chk(mem_cycle_active_n, 1);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run is a few thousand cycles
    initial begin
        #500000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {avs_read, avs_write, cpu_mem_valid, cpu_reset_instr, cpu_load_req, want_bus} = 6'h00;
        {power_on_reset_n, trap_request_n, rst} = 3'h7;
        avs_byteenable = 4'hf;
        avs_address = 7'h00;
        avs_writedata = 32'h0;
        cpu_mem_req = '0;
        wait_clocks = 4'h0;
        interrupt_level_n = 15'h7fff;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk({bus_grant, io_reset_out_n, mem_access_active_n}, 3'h3);
        av(1'b0, REG_MASK, 32'h0);
        chk(q, 0);
        av(1'b0, 7'h30, 32'h0);
        chk(q, 0);
        av(1'b1, REG_MASK, 32'h8000);
        for (int l = 1; l <= 15; l++) begin
            interrupt_level_n <= ~(15'h1 << (l - 1));
            repeat (6) @(posedge clk);
            chk(cpu_int_req, l <= 8);
            chk(cpu_int_level, (l <= 8) ? l : 0);
        end
        // Lines 3 and 9 together: level 3 wins; line 9 alone stays masked until the mask is set to 15
        interrupt_level_n <= 15'h7efb;
        repeat (6) @(posedge clk);
        chk(cpu_int_level, 3);
        interrupt_level_n <= 15'h7eff;
        repeat (6) @(posedge clk);
        chk(cpu_int_req, 0);
        av(1'b1, REG_MASK, 32'hf000);
        repeat (6) @(posedge clk);
        chk(cpu_int_level, 9);
        interrupt_level_n <= 15'h7fff;
        endt("interrupts");
        mem({1'b1, 1'b1, 1'b0, 16'h1234});
        chk(ph, 20'h01234);
        chk(n, 8);
        mem({1'b0, 1'b0, 1'b0, 16'h8ace});
        wait_clocks <= 4'h2;
        mem({1'b1, 1'b0, 1'b1, 16'h0010});
        chk(n >= 16 && n <= 40, 1);
        wait_clocks <= 4'h0;
        endt("memory cycles");
        av(1'b1, REG_MAP_BASE + 7'h04, 32'h5a);
        av(1'b0, REG_MAP_BASE + 7'h04, 32'h0);
        chk(q, 32'h5a);
        av(1'b1, REG_CTRL, 32'h3);
        mem({1'b1, 1'b0, 1'b0, 16'h1abc});
        chk(ph, 20'h5aabc);
        av(1'b1, REG_CTRL, 32'h1);
        av(1'b0, REG_MAP_BASE + 7'h04, 32'h0);
        chk(q, 0);
        av(1'b1, REG_CTRL, 32'h0);
        endt("mapper");
        want_bus <= 1'b1;
        wt(bus_grant, 1'b1);
        chk(bus_oe_n, 1);
        cpu_mem_valid <= 1'b1;
        repeat (30) @(posedge clk);
        chk(mem_cycle_active_n, 1);
        want_bus <= 1'b0;
        wt(cpu_mem_done, 1'b1);
        cpu_mem_valid <= 1'b0;
        chk(bus_grant, 0);
        endt("arbitration");
        for (int i = 0; i < 2; i++) begin
            if (i == 0) cpu_reset_instr <= 1'b1;
            else av(1'b1, REG_CTRL, 32'h4);
            @(posedge clk);
            cpu_reset_instr <= 1'b0;
            wt(io_reset_out_n, 1'b0);
            r0 = refs;
            wt(io_reset_out_n, 1'b1);
            chk(refs - r0 >= 2, 1);
        end
        r0 = refs;
        n = bus_edges;
        repeat (1000) @(posedge clk);
        chk(refs - r0 >= 29 && refs - r0 <= 31, 1);
        chk(bus_edges - n, 125);
        cpu_load_req <= 1'b1;
        @(posedge clk);
        cpu_load_req <= 1'b0;
        repeat (10) @(posedge clk);
        chk(last_ctx, {VEC_LOAD_WP, VEC_LOAD_PC});
        // Short pulse first: the filter must drop it
        trap_request_n <= 1'b0;
        repeat (5) @(posedge clk);
        trap_request_n <= 1'b1;
        repeat (5) @(posedge clk);
        trap_request_n <= 1'b0;
        repeat (12) @(posedge clk);
        trap_request_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk({traps[29:0], cpu_reset, io_reset_out_n}, 32'h5);
        endt("resets and trap");
        power_on_reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk({cpu_reset, io_reset_out_n}, 2'h2);
        power_on_reset_n <= 1'b1;
        wt(io_reset_out_n, 1'b1);
        repeat (10) @(posedge clk);
        chk(last_ctx, {VEC_RESET_WP, VEC_RESET_PC});
        endt("power-on reset");
        print_verdict;
    end
endmodule // system_bus_master_control_bench
`default_nettype wire
